// ### rtl/synth_port_pkg.sv
`default_nettype none
package synth_port_pkg;

   ////////////////////////////////////////////////////////////////////////////////
   // word layout: data field above, register select field in the last bits
   localparam int WORD_W    = 24;
   localparam int SEL_W     = 4;
   localparam int DATA_W    = WORD_W - SEL_W;
   localparam int REG_COUNT = 1 << SEL_W;

   typedef logic [WORD_W-1:0]                 word_t;
   typedef logic [DATA_W-1:0]                 data_t;
   typedef logic [SEL_W-1:0]                  sel_t;
   typedef logic [REG_COUNT-1:0][DATA_W-1:0]  bank_t;

   ////////////////////////////////////////////////////////////////////////////////
   // register indices and fields
   localparam sel_t  REG_ZERO_IDX  = 4'h0;
   localparam sel_t  PWR_REG_IDX   = 4'h1;
   localparam int    PWR_LSB       = 0;
   localparam int    PWR_W         = 4;
   localparam data_t REG_RESET_VAL = 20'h00000;

   typedef logic [PWR_W-1:0] pwr_bits_t;

   ////////////////////////////////////////////////////////////////////////////////
   // power sequencing states, gray along down -> wait -> run
   typedef enum logic [1:0] {
      PWR_DOWN      = 2'h0,
      PWR_WAIT_ZERO = 2'h1,
      PWR_RUN       = 2'h3
   } pwr_state_t;

   function automatic sel_t sel_of(input word_t w);
      return w[SEL_W-1:0];
   endfunction : sel_of

   function automatic data_t data_of(input word_t w);
      return w[WORD_W-1:SEL_W];
   endfunction : data_of

endpackage : synth_port_pkg
`default_nettype wire

// ### rtl/shift_link_if.sv
`timescale 1ns/1ps
`default_nettype none
interface shift_link_if;
   import synth_port_pkg::*;
   word_t shift_word;
   modport link (output shift_word);
   modport core (input  shift_word);
endinterface : shift_link_if
`default_nettype wire

// ### rtl/serial_shifter.sv
`timescale 1ns/1ps
`default_nettype none
module serial_shifter (
   input  wire logic         ser_clk,
   input  wire logic         ser_data,
   shift_link_if.link        lnk
);
   import synth_port_pkg::*;

   typedef struct packed {
      word_t shift;
   } link_state_t;

   link_state_t q;
   link_state_t d;

   ////////////////////////////////////////////////////////////////////////////////
   // no reset: the host clock stands still outside frames, and every word
   // is fully shifted before it is latched
   always_comb begin
      d       = q;
      d.shift = {q.shift[WORD_W-2:0], ser_data};
   end

   always_ff @(posedge ser_clk) begin
      q <= d;
   end

   assign lnk.shift_word = q.shift;

endmodule : serial_shifter
`default_nettype wire

// ### rtl/synth_serial_program_port.sv
`timescale 1ns/1ps
`default_nettype none
module synth_serial_program_port (
   input  wire logic                    clk,
   input  wire logic                    sys_rst,
   input  wire logic                    ser_clk,
   input  wire logic                    ser_data,
   input  wire logic                    latch_strobe,
   input  wire logic                    chip_enable,
   output var  synth_port_pkg::bank_t     cfg_regs,
   output var  synth_port_pkg::pwr_bits_t block_enable,
   output var  logic                    part_running,
   output var  logic                    load_pulse,
   output var  synth_port_pkg::sel_t      load_sel
);
   import synth_port_pkg::*;

   typedef struct packed {
      logic       le_s1;
      logic       le_s2;
      logic       le_s3;
      logic       ce_s1;
      logic       ce_s2;
      bank_t      bank;
      pwr_state_t pwr_state;
      pwr_bits_t  blk_en;
      logic       running;
      logic       load;
      sel_t       sel;
   } core_state_t;

   core_state_t          q;
   core_state_t          d;
   logic                 le_rise;
   logic                 zero_load;
   word_t                word_in;
   sel_t                 word_sel;
   data_t                word_data;
   logic [REG_COUNT-1:0] reg_hit;

   ////////////////////////////////////////////////////////////////////////////////
   // decoding helpers for the next-state logic below

   // reset image of the whole core state; the shift register has none of its own
   function automatic core_state_t reset_state();
      core_state_t r;
      r.le_s1     = 1'b0;
      r.le_s2     = 1'b0;
      r.le_s3     = 1'b0;
      r.ce_s1     = 1'b0;
      r.ce_s2     = 1'b0;
      r.bank      = {REG_COUNT{REG_RESET_VAL}};
      r.pwr_state = PWR_DOWN;
      r.blk_en    = '0;
      r.running   = 1'b0;
      r.load      = 1'b0;
      r.sel       = '0;
      return r;
   endfunction : reset_state

   // a rise seen between the last two synchroniser stages; both idle low after
   // reset, so no false edge follows it
   function automatic logic strobe_rise(
      input logic now_v,
      input logic last_v
   );
      return now_v & ~last_v;
   endfunction : strobe_rise

   // the part is awake in both powered states
   function automatic logic is_awake(input pwr_state_t st);
      return st != PWR_DOWN;
   endfunction : is_awake

   // fully in operation only once register zero has been rewritten
   function automatic logic is_running(input pwr_state_t st);
      return st == PWR_RUN;
   endfunction : is_running

   // next power state from the synchronised enable level and this cycle's load;
   // a select-zero load in the same cycle as wake-up does not count, the part must
   // already be awake when register zero is rewritten
   function automatic pwr_state_t pwr_step(
      input pwr_state_t cur,
      input logic       ce_on,
      input logic       zero_hit
   );
      pwr_state_t nxt;
      nxt = cur;
      case (cur)
         PWR_DOWN: begin
            if (ce_on) begin
               nxt = PWR_WAIT_ZERO;
            end
         end
         PWR_WAIT_ZERO: begin
            if (!ce_on) begin
               nxt = PWR_DOWN;
            end else if (zero_hit) begin
               nxt = PWR_RUN;
            end
         end
         PWR_RUN: begin
            if (!ce_on) begin
               nxt = PWR_DOWN;
            end
         end
         default: begin
            nxt = PWR_DOWN;
         end
      endcase
      return nxt;
   endfunction : pwr_step

   // block enables: the power bits while awake, all off while down
   function automatic pwr_bits_t enables_for(
      input pwr_state_t st,
      input data_t      pwr_word
   );
      pwr_bits_t en;
      en = '0;
      if (is_awake(st)) begin
         en = pwr_word[PWR_LSB +: PWR_W];
      end
      return en;
   endfunction : enables_for

   ////////////////////////////////////////////////////////////////////////////////
   // limitations of the crossing
   // - the shift word is not resynchronised; it is safe only because the host
   //   keeps its clock still from the strobe rise until the load has been taken
   // - a strobe narrower than one core clock can be missed altogether
   // - a strobe with no preceding word loads whatever the shift register holds

   ////////////////////////////////////////////////////////////////////////////////
   // link side: shift register on the host's own clock
   shift_link_if lnk_if ();

   serial_shifter u_shifter (
      .ser_clk  (ser_clk),
      .ser_data (ser_data),
      .lnk      (lnk_if.link)
   );

   assign word_in = lnk_if.shift_word;

   ////////////////////////////////////////////////////////////////////////////////
   // core side
   // the word crosses as held data: it is read only after the strobe has passed
   // two flops, and the host does not clock while the strobe is high
   assign le_rise   = strobe_rise(q.le_s2, q.le_s3);
   assign word_sel  = sel_of(word_in);
   assign word_data = data_of(word_in);
   assign zero_load = le_rise && (word_sel == REG_ZERO_IDX);

   ////////////////////////////////////////////////////////////////////////////////
   // one write enable per register, so only the selected register opens on a
   // strobe and the others keep their value
   for (genvar n = 0; n < REG_COUNT; n++) begin : g_reg_hit
      assign reg_hit[n] = le_rise && (word_sel == sel_t'(n));
   end

   ////////////////////////////////////////////////////////////////////////////////
   // next state
   always_comb begin
      d       = q;

      // synchronisers: only the second stage feeds logic, the third is edge memory
      d.le_s1 = latch_strobe;
      d.le_s2 = q.le_s1;
      d.le_s3 = q.le_s2;
      d.ce_s1 = chip_enable;
      d.ce_s2 = q.ce_s1;

      // register bank: writes are taken whatever the power state
      for (int n = 0; n < REG_COUNT; n++) begin
         if (reg_hit[n]) begin
            d.bank[n] = word_data;
         end
      end

      // one pulse per load; the select stays until the next load so a slow
      // observer can still tell which register was written
      d.load = le_rise;
      if (le_rise) begin
         d.sel = word_sel;
      end

      // power sequencing
      d.pwr_state = pwr_step(q.pwr_state, q.ce_s2, zero_load);

      // enables follow the power bits as they stand, including a write this cycle
      d.blk_en  = enables_for(d.pwr_state, d.bank[PWR_REG_IDX]);
      d.running = is_running(d.pwr_state);

      if (sys_rst) begin
         d = reset_state();
      end
   end

   always_ff @(posedge clk) begin
      q <= d;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // outputs, each straight from its flop
   assign cfg_regs     = q.bank;
   assign block_enable = q.blk_en;
   assign part_running = q.running;
   assign load_pulse   = q.load;
   assign load_sel     = q.sel;

endmodule : synth_serial_program_port
`default_nettype wire

// ### test/synth_port_props.sv
`timescale 1ns/1ps
`default_nettype none
module synth_port_props (
   input wire logic                      clk,
   input wire logic                      sys_rst,
   input wire logic                      latch_strobe,
   input wire logic                      chip_enable,
   input wire synth_port_pkg::bank_t     cfg_regs,
   input wire synth_port_pkg::pwr_bits_t block_enable,
   input wire logic                      part_running,
   input wire logic                      load_pulse,
   input wire synth_port_pkg::sel_t      load_sel
);
   import synth_port_pkg::*;
   default clocking @(posedge clk); endclocking
   default disable iff (sys_rst);
   sequence strobe_rise;
      $rose(latch_strobe);
   endsequence
   chk_load_follows: assert property (strobe_rise |-> ##[2:5] load_pulse)
      else $error("no load");
   chk_pulse_single: assert property (load_pulse |=> !load_pulse)
      else $error("long load");
   chk_sel_hold: assert property (!load_pulse |-> $stable(load_sel))
      else $error("sel moved");
   chk_off_clears: assert property (!chip_enable [*5] |-> !block_enable && !part_running)
      else $error("still on");
   chk_enable_bits: assert property (chip_enable [*5] |->
      block_enable == cfg_regs[PWR_REG_IDX][PWR_LSB +: PWR_W])
      else $error("bad bits");
   chk_run_zero: assert property ($rose(part_running) |->
      load_pulse && load_sel == REG_ZERO_IDX)
      else $error("bad run");
endmodule : synth_port_props
bind synth_serial_program_port synth_port_props u_synth_port_props (.clk, .sys_rst,
   .latch_strobe, .chip_enable, .cfg_regs, .block_enable, .part_running, .load_pulse, .load_sel);
`default_nettype wire

// ### test/serial_host.sv
`timescale 1ns/1ps
`default_nettype none
module serial_host (
   output logic ser_clk,
   output logic ser_data,
   output logic latch_strobe
);
   import synth_port_pkg::*;
   initial {ser_clk, ser_data, latch_strobe} = 3'h0;
   // clock stands still between words; released data shows the inverse
   task automatic send(input word_t w);
      #3;
      for (int i = WORD_W - 1; i >= 0; i--) begin
         ser_data = w[i];
         #80 ser_clk = 1'b1;
         #80 ser_clk = 1'b0;
      end
      ser_data = ~ser_data;
      #80 latch_strobe = 1'b1;
      #80 latch_strobe = 1'b0;
      #80;
   endtask : send
endmodule : serial_host
`default_nettype wire

// ### test/synth_serial_program_port_tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, a) begin check_count++; if ((a) !== (e)) begin err_count++; \
   $display("CHECK FAILED %s exp %h got %h", n, e, a); end end
module synth_serial_program_port_tb;
   import synth_port_pkg::*;
   logic      clk = 1'b0;
   logic      sys_rst = 1'b1;
   logic      chip_enable = 1'b0;
   wire       ser_clk, ser_data, latch_strobe;
   bank_t     cfg_regs;
   pwr_bits_t block_enable;
   logic      part_running, load_pulse;
   sel_t      load_sel;
   int        err_count = 0, check_count = 0, cyc = 0;
   always #2.5 clk = ~clk;
   serial_host u_serial_host (.ser_clk, .ser_data, .latch_strobe);
   synth_serial_program_port u_synth_serial_program_port (.clk, .sys_rst, .ser_clk, .ser_data,
      .latch_strobe, .chip_enable, .cfg_regs, .block_enable, .part_running, .load_pulse, .load_sel);
   task automatic end_of_test;
      $display("errors %0d checks %0d", err_count, check_count);
      if (err_count == 0 && check_count > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : end_of_test
   task automatic set_ce(input logic v);
      @(posedge clk);
      #1 chip_enable = v;
      repeat (8) @(posedge clk);
   endtask : set_ce
   task automatic t_all_sel;
      word_t w;
      for (int i = 0; i < REG_COUNT; i++) begin
         w = {4'(i), 16'hc3a5, 4'(i)};
         u_serial_host.send(w);
         `CHK("reg", w[23:4], cfg_regs[i])
         `CHK("sel", w[3:0], load_sel)
      end
      `CHK("bits", 4'h0, block_enable)
      `CHK("run", 1'b0, part_running)
      $display("t_all_sel done");
   endtask : t_all_sel
   task automatic t_power;
      set_ce(1'b1);
      `CHK("bits", 4'h5, block_enable)
      `CHK("run", 1'b0, part_running)
      u_serial_host.send(24'h0000a1);
      `CHK("bits", 4'ha, block_enable)
      u_serial_host.send(24'h123450);
      `CHK("run", 1'b1, part_running)
      set_ce(1'b0);
      `CHK("bits", 4'h0, block_enable)
      set_ce(1'b1);
      `CHK("run", 1'b0, part_running)
      $display("t_power done");
   endtask : t_power
   initial begin
      repeat (8) @(posedge clk);
      #1 sys_rst = 1'b0;
      t_all_sel();
      t_power();
      end_of_test();
   end
   always @(posedge clk) begin
      cyc++;
      if (cyc == 30000) begin
         err_count++;
         end_of_test();
      end
   end
endmodule : synth_serial_program_port_tb
`default_nettype wire
